// [hw/mcr_pkg.sv]
package mcr_pkg;

	// serial port sequencing
	typedef enum logic [1:0] {ST_CMD = 2'b00, ST_DATA = 2'b01, ST_DONE = 2'b10} mcr_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [6:0] OFS_C_ACT_GAIN = 7'h2C;
	localparam logic [6:0] OFS_A_RCT_GAIN = 7'h2D;
	localparam logic [6:0] OFS_B_RCT_GAIN = 7'h2E;
	localparam logic [6:0] OFS_C_RCT_GAIN = 7'h2F;
	localparam logic [6:0] OFS_A_APP_GAIN = 7'h30;
	localparam logic [6:0] OFS_B_APP_GAIN = 7'h31;
	localparam logic [6:0] OFS_C_APP_GAIN = 7'h32;
	localparam logic [6:0] OFS_A_VRMS_OFS = 7'h33;
	localparam logic [6:0] OFS_B_VRMS_OFS = 7'h34;
	localparam logic [6:0] OFS_C_VRMS_OFS = 7'h35;
	localparam logic [6:0] OFS_A_IRMS_OFS = 7'h36;
	localparam logic [6:0] OFS_B_IRMS_OFS = 7'h37;
	localparam logic [6:0] OFS_C_IRMS_OFS = 7'h38;
	localparam logic [6:0] OFS_A_ACT_OFS = 7'h39;
	localparam logic [6:0] OFS_B_ACT_OFS = 7'h3A;
	localparam logic [6:0] OFS_C_ACT_OFS = 7'h3B;
	localparam logic [6:0] OFS_A_RCT_OFS = 7'h3C;
	localparam logic [6:0] OFS_B_RCT_OFS = 7'h3D;
	localparam logic [6:0] OFS_C_RCT_OFS = 7'h3E;
	localparam logic [6:0] OFS_A_PH_CAL = 7'h3F;
	localparam logic [6:0] OFS_B_PH_CAL = 7'h40;
	localparam logic [6:0] OFS_C_PH_CAL = 7'h41;
	localparam logic [6:0] OFS_ACT_DIV = 7'h42;
	localparam logic [6:0] OFS_RCT_DIV = 7'h43;
	localparam logic [6:0] OFS_APP_DIV = 7'h44;
	localparam logic [6:0] OFS_ACT_NUM = 7'h45;
	localparam logic [6:0] OFS_ACT_DEN = 7'h46;
	localparam logic [6:0] OFS_RCT_NUM = 7'h47;
	localparam logic [6:0] OFS_RCT_DEN = 7'h48;
	localparam logic [6:0] OFS_ONES_COUNT = 7'h7E;
	localparam logic [6:0] OFS_DIE_VERSION = 7'h7F;
	localparam logic [6:0] OFS_FIRST = OFS_C_ACT_GAIN;
	localparam logic [6:0] OFS_LAST = OFS_RCT_DEN;

	////////////////////////////////////////////////////////////////////////////////
	// fields, masks, reset values, counts
	localparam int FLAG_MSB = 15;
	localparam int FLAG_LSB = 13;
	localparam logic [15:0] MASK_7 = 16'h007F;
	localparam logic [15:0] MASK_8 = 16'h00FF;
	localparam logic [15:0] MASK_12 = 16'h0FFF;
	localparam logic [15:0] MASK_16 = 16'hFFFF;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_DEN = 16'h003F;
	localparam logic [7:0] RST_ONES = 8'h00;
	localparam logic [4:0] LAST_BIT_BYTE = 5'h07;
	localparam logic [4:0] LAST_BIT_HALF = 5'h0F;
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [2:0] PIN_IDLE = 3'h2;

	// stored bits of an in-range register
	function automatic logic [15:0] reg_mask(input logic [6:0] a);
		if (a <= OFS_C_RCT_OFS)
			return MASK_12;
		else if (a <= OFS_C_PH_CAL)
			return MASK_7;
		else if (a <= OFS_APP_DIV)
			return MASK_8;
		else if (a == OFS_ACT_DEN || a == OFS_RCT_DEN)
			return MASK_12;
		else
			return MASK_16;
	endfunction

	// index of the last data bit of a transfer: one byte or two
	function automatic logic [4:0] reg_last_bit(input logic [6:0] a);
		logic [15:0] m;
		m = reg_mask(a);
		return (a >= OFS_FIRST && a <= OFS_LAST && m[8]) ? LAST_BIT_HALF : LAST_BIT_BYTE;
	endfunction

	function automatic logic [15:0] reg_reset(input logic [6:0] a);
		return (a == OFS_ACT_DEN || a == OFS_RCT_DEN) ? RST_DEN : RST_ZERO;
	endfunction

	function automatic logic [7:0] count_ones(input logic [15:0] v);
		logic [7:0] n;
		n = 8'h00;
		for (int i = 0; i < 16; i++)
			n = n + {7'h00, v[i]};
		return n;
	endfunction

endpackage

// [hw/mcr_register_bank.sv]
`timescale 1ns/1ps

// Notes on behaviour
// - The three reactive power gain registers are signed 12-bit scale factors of 0.0244 percent per step.
// - The three apparent power gain registers are signed 12-bit scale factors of 0.0244 percent per step.
// - Each phase calibration register is a signed 7-bit shift between current and voltage timing.
// - Bits 15, 14 and 13 of the active numerator read back the reverse active power flags of phases A, B, C.
// - Bits 15, 14 and 13 of the reactive numerator read back the reverse reactive power flags of phases A, B, C.
// - The active pulse rate is scaled by its numerator over a 12-bit denominator that resets to 0x3F.
// - The reactive pulse rate is scaled by its 16-bit numerator over a 12-bit denominator resetting to 0x3F.
// - The 8-bit read-only checksum holds the number of one bits in the last word read over the port.
// - Read-write registers take reads and writes, read-only registers ignore writes and only answer reads.
// - Gains, offsets and phase calibration leave as signed values, all other registers as unsigned.
// - Each phase has signed 12-bit active and reactive power offsets that reset to zero.
// - Three unsigned 8-bit energy dividers reset to zero and go to the energy accumulators.
module mcr_register_bank #(
	parameter logic [7:0] DIE_VERSION = 8'h5A // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe_n,
	input wire logic [2:0] active_reverse,
	input wire logic [2:0] reactive_reverse,
	output logic signed [11:0] phase_c_active_power_gain,
	output logic signed [11:0] phase_a_reactive_power_gain,
	output logic signed [11:0] phase_b_reactive_power_gain,
	output logic signed [11:0] phase_c_reactive_power_gain,
	output logic signed [11:0] phase_a_apparent_power_gain,
	output logic signed [11:0] phase_b_apparent_power_gain,
	output logic signed [11:0] phase_c_apparent_power_gain,
	output logic signed [11:0] phase_a_voltage_rms_offset,
	output logic signed [11:0] phase_b_voltage_rms_offset,
	output logic signed [11:0] phase_c_voltage_rms_offset,
	output logic signed [11:0] phase_a_current_rms_offset,
	output logic signed [11:0] phase_b_current_rms_offset,
	output logic signed [11:0] phase_c_current_rms_offset,
	output logic signed [11:0] phase_a_active_power_offset,
	output logic signed [11:0] phase_b_active_power_offset,
	output logic signed [11:0] phase_c_active_power_offset,
	output logic signed [11:0] phase_a_reactive_power_offset,
	output logic signed [11:0] phase_b_reactive_power_offset,
	output logic signed [11:0] phase_c_reactive_power_offset,
	output logic signed [6:0] phase_a_phase_calibration,
	output logic signed [6:0] phase_b_phase_calibration,
	output logic signed [6:0] phase_c_phase_calibration,
	output logic [7:0] active_energy_divider,
	output logic [7:0] reactive_energy_divider,
	output logic [7:0] apparent_energy_divider,
	output logic [15:0] active_pulse_scale_numerator,
	output logic [11:0] active_pulse_scale_denominator,
	output logic [15:0] reactive_pulse_scale_numerator,
	output logic [11:0] reactive_pulse_scale_denominator
);

	logic rst_s1_q;
	logic rst_n_q;
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic [2:0] pin_s3_q;
	logic [2:0] pin_f_q;
	logic sclk_prev_q;
	mcr_pkg::mcr_state_t state_q;
	mcr_pkg::mcr_state_t state_d;
	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic [7:0] cmd_q;
	logic [15:0] in_sh_q;
	logic [15:0] out_sh_q;
	logic [15:0] rd_word_q;
	logic [7:0] ones_q;
	logic sdo_q;
	logic [15:0] regs_q [mcr_pkg::OFS_FIRST:mcr_pkg::OFS_LAST];

	////////////////////////////////////////////////////////////////////////////////
	// reset release: async assert, two-flop release
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// pins pass three flops; a level counts once the last two agree
	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			pin_s1_q <= mcr_pkg::PIN_IDLE;
			pin_s2_q <= mcr_pkg::PIN_IDLE;
			pin_s3_q <= mcr_pkg::PIN_IDLE;
			pin_f_q <= mcr_pkg::PIN_IDLE;
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= {spi_sdi, spi_cs_n, spi_sclk};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
			sclk_prev_q <= pin_f_q[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// decode of the serial frame
	wire sclk_f = pin_f_q[0];
	wire cs_act = ~pin_f_q[1];
	wire sdi_f = pin_f_q[2];
	wire sclk_rise = sclk_f & ~sclk_prev_q;
	wire sclk_fall = ~sclk_f & sclk_prev_q;
	wire [7:0] cmd_nx = {cmd_q[6:0], sdi_f};
	wire is_write = cmd_q[7];
	wire cmd_done = cs_act && state_q == mcr_pkg::ST_CMD && sclk_rise && cnt_q == mcr_pkg::CMD_LAST_BIT;
	wire [6:0] addr = (state_q == mcr_pkg::ST_CMD) ? cmd_nx[6:0] : cmd_q[6:0];
	wire [4:0] last_bit = mcr_pkg::reg_last_bit(addr);
	wire data_last = cs_act && state_q == mcr_pkg::ST_DATA && sclk_rise && cnt_q == last_bit;
	wire wr_commit = data_last & is_write;
	wire rd_commit = data_last & ~is_write;
	wire [15:0] wr_data = {in_sh_q[14:0], sdi_f};
	wire in_rng = addr >= mcr_pkg::OFS_FIRST && addr <= mcr_pkg::OFS_LAST;
	// only the calibration window stores; read-only and reserved addresses drop writes
	wire wr_hit = wr_commit & in_rng;

	// read value; flags replace the top numerator bits on the way out
	wire [15:0] rd_base = in_rng ? regs_q[addr] :
		(addr == mcr_pkg::OFS_ONES_COUNT) ? {8'h00, ones_q} :
		(addr == mcr_pkg::OFS_DIE_VERSION) ? {8'h00, DIE_VERSION} : 16'h0000;
	wire [15:0] rd_val = (addr == mcr_pkg::OFS_ACT_NUM) ? {active_reverse, rd_base[12:0]} :
		(addr == mcr_pkg::OFS_RCT_NUM) ? {reactive_reverse, rd_base[12:0]} : rd_base;
	// one-byte words leave the shifter from its top byte
	wire [15:0] rd_load = (last_bit == mcr_pkg::LAST_BIT_HALF) ? rd_val : {rd_val[7:0], 8'h00};

	// frame sequencing; a raised chip select always returns to command
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (!cs_act)
		begin
			state_d = mcr_pkg::ST_CMD;
			cnt_d = 5'h00;
		end
		else if (sclk_rise)
		begin
			case (state_q)
				mcr_pkg::ST_CMD:
				begin
					state_d = cmd_done ? mcr_pkg::ST_DATA : mcr_pkg::ST_CMD;
					cnt_d = cmd_done ? 5'h00 : cnt_q + 5'h01;
				end
				mcr_pkg::ST_DATA:
				begin
					state_d = data_last ? mcr_pkg::ST_DONE : mcr_pkg::ST_DATA;
					cnt_d = cnt_q + 5'h01;
				end
				mcr_pkg::ST_DONE:
					state_d = mcr_pkg::ST_DONE;
				default:
					state_d = mcr_pkg::ST_CMD;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q <= mcr_pkg::ST_CMD;
			cnt_q <= 5'h00;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shifters: sample on rising clock, drive out on falling clock
	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			cmd_q <= 8'h00;
			in_sh_q <= 16'h0000;
		end
		else if (cs_act && sclk_rise)
		begin
			if (state_q == mcr_pkg::ST_CMD)
				cmd_q <= cmd_nx;
			if (state_q == mcr_pkg::ST_DATA)
				in_sh_q <= wr_data;
		end
	end

	// word is frozen at the command so a flag change mid-read cannot tear it
	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			out_sh_q <= 16'h0000;
			rd_word_q <= 16'h0000;
			sdo_q <= 1'b0;
		end
		else if (cmd_done && !cmd_nx[7])
		begin
			out_sh_q <= rd_load;
			rd_word_q <= rd_val;
		end
		else if (cs_act && sclk_fall && state_q == mcr_pkg::ST_DATA && !is_write)
		begin
			sdo_q <= out_sh_q[15];
			out_sh_q <= {out_sh_q[14:0], 1'b0};
		end
	end

	// pin driven from the data phase of a read until chip select rises
	assign spi_sdo = sdo_q;
	assign spi_sdo_oe_n = ~(cs_act && state_q != mcr_pkg::ST_CMD && !is_write);

	// ones count of the last completed read, itself included
	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			ones_q <= mcr_pkg::RST_ONES;
		else if (rd_commit)
			ones_q <= mcr_pkg::count_ones(rd_word_q);
	end

	////////////////////////////////////////////////////////////////////////////////
	// register storage
	always_ff @(posedge sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			for (int i = int'(mcr_pkg::OFS_FIRST); i <= int'(mcr_pkg::OFS_LAST); i++)
				regs_q[i] <= mcr_pkg::reg_reset(7'(i));
		end
		else if (wr_hit)
			regs_q[addr] <= wr_data & mcr_pkg::reg_mask(addr);
	end

	// signed calibration values to the metering datapath
	assign phase_c_active_power_gain = regs_q[mcr_pkg::OFS_C_ACT_GAIN][11:0];
	assign phase_a_reactive_power_gain = regs_q[mcr_pkg::OFS_A_RCT_GAIN][11:0];
	assign phase_b_reactive_power_gain = regs_q[mcr_pkg::OFS_B_RCT_GAIN][11:0];
	assign phase_c_reactive_power_gain = regs_q[mcr_pkg::OFS_C_RCT_GAIN][11:0];
	assign phase_a_apparent_power_gain = regs_q[mcr_pkg::OFS_A_APP_GAIN][11:0];
	assign phase_b_apparent_power_gain = regs_q[mcr_pkg::OFS_B_APP_GAIN][11:0];
	assign phase_c_apparent_power_gain = regs_q[mcr_pkg::OFS_C_APP_GAIN][11:0];
	assign phase_a_voltage_rms_offset = regs_q[mcr_pkg::OFS_A_VRMS_OFS][11:0];
	assign phase_b_voltage_rms_offset = regs_q[mcr_pkg::OFS_B_VRMS_OFS][11:0];
	assign phase_c_voltage_rms_offset = regs_q[mcr_pkg::OFS_C_VRMS_OFS][11:0];
	assign phase_a_current_rms_offset = regs_q[mcr_pkg::OFS_A_IRMS_OFS][11:0];
	assign phase_b_current_rms_offset = regs_q[mcr_pkg::OFS_B_IRMS_OFS][11:0];
	assign phase_c_current_rms_offset = regs_q[mcr_pkg::OFS_C_IRMS_OFS][11:0];
	assign phase_a_active_power_offset = regs_q[mcr_pkg::OFS_A_ACT_OFS][11:0];
	assign phase_b_active_power_offset = regs_q[mcr_pkg::OFS_B_ACT_OFS][11:0];
	assign phase_c_active_power_offset = regs_q[mcr_pkg::OFS_C_ACT_OFS][11:0];
	assign phase_a_reactive_power_offset = regs_q[mcr_pkg::OFS_A_RCT_OFS][11:0];
	assign phase_b_reactive_power_offset = regs_q[mcr_pkg::OFS_B_RCT_OFS][11:0];
	assign phase_c_reactive_power_offset = regs_q[mcr_pkg::OFS_C_RCT_OFS][11:0];
	assign phase_a_phase_calibration = regs_q[mcr_pkg::OFS_A_PH_CAL][6:0];
	assign phase_b_phase_calibration = regs_q[mcr_pkg::OFS_B_PH_CAL][6:0];
	assign phase_c_phase_calibration = regs_q[mcr_pkg::OFS_C_PH_CAL][6:0];

	// unsigned dividers and pulse scaling
	assign active_energy_divider = regs_q[mcr_pkg::OFS_ACT_DIV][7:0];
	assign reactive_energy_divider = regs_q[mcr_pkg::OFS_RCT_DIV][7:0];
	assign apparent_energy_divider = regs_q[mcr_pkg::OFS_APP_DIV][7:0];
	assign active_pulse_scale_numerator = regs_q[mcr_pkg::OFS_ACT_NUM];
	assign active_pulse_scale_denominator = regs_q[mcr_pkg::OFS_ACT_DEN][11:0];
	assign reactive_pulse_scale_numerator = regs_q[mcr_pkg::OFS_RCT_NUM];
	assign reactive_pulse_scale_denominator = regs_q[mcr_pkg::OFS_RCT_DEN][11:0];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n_q);

	a_write_stores_word: assert property (
		wr_hit |=> regs_q[$past(addr)] == ($past(wr_data) & mcr_pkg::reg_mask($past(addr))))
		else $error("written word not stored");
	a_ro_ignores_write: assert property (
		wr_commit && addr == mcr_pkg::OFS_ONES_COUNT |=> $stable(ones_q))
		else $error("checksum changed by a write");
	a_reserved_reads_zero: assert property (
		addr > mcr_pkg::OFS_LAST && addr < mcr_pkg::OFS_ONES_COUNT |-> rd_val == 16'h0000)
		else $error("reserved address not zero");
	a_ones_after_read: assert property (
		rd_commit |=> ones_q == mcr_pkg::count_ones($past(rd_word_q)))
		else $error("checksum wrong after read");
	a_act_flags_read: assert property (
		addr == mcr_pkg::OFS_ACT_NUM |-> rd_val[mcr_pkg::FLAG_MSB:mcr_pkg::FLAG_LSB] == active_reverse)
		else $error("active reverse flags wrong");
	a_rct_flags_read: assert property (
		addr == mcr_pkg::OFS_RCT_NUM |-> rd_val[mcr_pkg::FLAG_MSB:mcr_pkg::FLAG_LSB] == reactive_reverse)
		else $error("reactive reverse flags wrong");
	a_ph_cal_width: assert property (
		addr >= mcr_pkg::OFS_A_PH_CAL && addr <= mcr_pkg::OFS_C_PH_CAL |-> rd_val[15:7] == 9'h000)
		else $error("phase calibration wider than seven bits");
	a_den_only_by_write: assert property (
		!(wr_hit && (addr == mcr_pkg::OFS_ACT_DEN || addr == mcr_pkg::OFS_RCT_DEN))
		|=> $stable(active_pulse_scale_denominator) && $stable(reactive_pulse_scale_denominator))
		else $error("denominator changed without write");
	a_div_only_by_write: assert property (
		!wr_hit |=> $stable(active_energy_divider) && $stable(apparent_energy_divider))
		else $error("divider changed without write");
	a_gain_only_by_write: assert property (
		!wr_hit |=> $stable(phase_a_reactive_power_gain) && $stable(phase_c_apparent_power_gain)
		&& $stable(phase_b_active_power_offset))
		else $error("calibration changed without write");
	a_sdo_released: assert property (
		!cs_act |-> spi_sdo_oe_n)
		else $error("output driven outside a frame");

	// pin enable and data timing; a late enable would hand the host a floating bit
	a_read_drives_pin: assert property (
		cs_act && state_q == mcr_pkg::ST_DATA && !is_write |-> !spi_sdo_oe_n)
		else $error("read data phase left the output released");
	a_write_keeps_pin: assert property (
		is_write && state_q != mcr_pkg::ST_CMD |-> spi_sdo_oe_n)
		else $error("output driven during a write");
	a_sdo_on_fall: assert property (
		!(cs_act && sclk_fall) |=> $stable(spi_sdo))
		else $error("output bit changed away from a clock fall");
	a_data_count: assert property (
		state_q == mcr_pkg::ST_DATA |-> cnt_q <= last_bit)
		else $error("data phase ran past its last bit");
	a_cut_frame_inert: assert property (
		!cs_act |-> !wr_hit && !rd_commit)
		else $error("transfer committed outside a frame");
	a_reserved_no_store: assert property (
		wr_commit && !in_rng |=> $stable(active_pulse_scale_numerator) && $stable(phase_a_phase_calibration))
		else $error("reserved write reached the store");
	a_ones_need_read: assert property (
		!rd_commit |=> $stable(ones_q))
		else $error("checksum changed without a read");
	a_version_value: assert property (
		addr == mcr_pkg::OFS_DIE_VERSION |-> rd_val == {8'h00, DIE_VERSION})
		else $error("version read wrong");

	// stored widths and signs; stray high bits would skew the datapath scaling
	a_ph_cal_stored: assert property (
		regs_q[mcr_pkg::OFS_B_PH_CAL][15:7] == 9'h000 && regs_q[mcr_pkg::OFS_C_PH_CAL][15:7] == 9'h000)
		else $error("phase calibration store wider than seven bits");
	a_gain_stored: assert property (
		regs_q[mcr_pkg::OFS_B_RCT_GAIN][15:12] == 4'h0 && regs_q[mcr_pkg::OFS_A_APP_GAIN][15:12] == 4'h0
		&& regs_q[mcr_pkg::OFS_C_ACT_OFS][15:12] == 4'h0)
		else $error("calibration store wider than twelve bits");
	a_signed_out: assert property (
		(phase_a_phase_calibration < 0) == regs_q[mcr_pkg::OFS_A_PH_CAL][6]
		&& (phase_b_reactive_power_gain < 0) == regs_q[mcr_pkg::OFS_B_RCT_GAIN][11])
		else $error("calibration value lost its sign");

	c_write_frame: cover property (wr_hit ##1 !cs_act);
	c_read_checksum: cover property (rd_commit && addr == mcr_pkg::OFS_ONES_COUNT);
	c_read_numerator: cover property (rd_commit && addr == mcr_pkg::OFS_ACT_NUM);
	c_cut_frame: cover property (cs_act && state_q == mcr_pkg::ST_DATA ##1 !cs_act);
	c_read_reserved: cover property (rd_commit && addr > mcr_pkg::OFS_LAST && addr < mcr_pkg::OFS_ONES_COUNT);

endmodule

// [test/mcr_host.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// host side of the serial port: clock idles low, msb first, device samples on the rise
module mcr_host (
	input wire logic sys_clk,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe_n
);
	// phases well above the two cycles the device filter needs
	localparam int HALF = 8;

	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// command byte then nclk data bits of a len-bit word; nclk below len aborts the frame
	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] data, input int len,
		input int nclk, output logic [15:0] rdata);
		logic [23:0] sh;
		sh = {wr, addr, (len == 16) ? data : {data[7:0], 8'h00}};
		rdata = 16'h0000;
		@(negedge sys_clk);
		spi_cs_n = 1'b0;
		for (int i = 0; i < 8 + nclk; i++)
		begin
			spi_sdi = sh[23];
			sh = sh << 1;
			idle(HALF);
			if (i >= 8)
				rdata = {rdata[14:0], spi_sdo ^ spi_sdo_oe_n}; // a released line reads inverted
			spi_sclk = 1'b1;
			idle(HALF);
			spi_sclk = 1'b0;
		end
		idle(HALF);
		spi_cs_n = 1'b1;
		// a released line never keeps its last level, so stale data cannot look valid
		spi_sdi = ~spi_sdi;
		idle(HALF);
	endtask
endmodule

// [test/metering_calibration_register_bank_test.sv]
`timescale 1ns/1ps

module metering_calibration_register_bank_test;
	localparam logic [7:0] VERSION = 8'hC3; // arbitrary value
	localparam int LIMIT = 90000;

	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] active_reverse = 3'h0;
	logic [2:0] reactive_reverse = 3'h0;
	wire spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
	wire [11:0] w12 [0:18];
	wire [6:0] w7 [0:2];
	wire [7:0] w8 [0:2];
	wire [15:0] num [0:1];
	wire [11:0] den [0:1];
	logic [15:0] model [44:72];
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	mcr_host i_mcr_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n));

	mcr_register_bank #(.DIE_VERSION(VERSION)) i_mcr_register_bank (.sys_clk(sys_clk), .resetn(resetn),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
		.spi_sdo_oe_n(spi_sdo_oe_n), .active_reverse(active_reverse), .reactive_reverse(reactive_reverse),
		.phase_c_active_power_gain(w12[0]), .phase_a_reactive_power_gain(w12[1]),
		.phase_b_reactive_power_gain(w12[2]), .phase_c_reactive_power_gain(w12[3]),
		.phase_a_apparent_power_gain(w12[4]), .phase_b_apparent_power_gain(w12[5]),
		.phase_c_apparent_power_gain(w12[6]), .phase_a_voltage_rms_offset(w12[7]),
		.phase_b_voltage_rms_offset(w12[8]), .phase_c_voltage_rms_offset(w12[9]),
		.phase_a_current_rms_offset(w12[10]), .phase_b_current_rms_offset(w12[11]),
		.phase_c_current_rms_offset(w12[12]), .phase_a_active_power_offset(w12[13]),
		.phase_b_active_power_offset(w12[14]), .phase_c_active_power_offset(w12[15]),
		.phase_a_reactive_power_offset(w12[16]), .phase_b_reactive_power_offset(w12[17]),
		.phase_c_reactive_power_offset(w12[18]), .phase_a_phase_calibration(w7[0]),
		.phase_b_phase_calibration(w7[1]), .phase_c_phase_calibration(w7[2]),
		.active_energy_divider(w8[0]), .reactive_energy_divider(w8[1]), .apparent_energy_divider(w8[2]),
		.active_pulse_scale_numerator(num[0]), .active_pulse_scale_denominator(den[0]),
		.reactive_pulse_scale_numerator(num[1]), .reactive_pulse_scale_denominator(den[1]));

	// 25 MHz system clock
	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// stored width of each register; zero outside the bank
	function automatic logic [15:0] mk(input logic [6:0] a);
		if (a < 7'h2C || a > 7'h48) return 16'h0000;
		if (a <= 7'h3E || a == 7'h46 || a == 7'h48) return 16'h0FFF;
		if (a <= 7'h41) return 16'h007F;
		if (a <= 7'h44) return 16'h00FF;
		return 16'hFFFF;
	endfunction

	// wider registers travel as two bytes
	function automatic int len(input logic [6:0] a);
		return mk(a) > 16'h00FF ? 16 : 8;
	endfunction

	function automatic logic [15:0] port_of(input logic [6:0] a);
		if (a <= 7'h3E) return {4'h0, w12[a - 7'h2C]};
		if (a <= 7'h41) return {9'h000, w7[a - 7'h3F]};
		if (a <= 7'h44) return {8'h00, w8[a - 7'h42]};
		if (a[0]) return num[(a - 7'h45) >> 1];
		return {4'h0, den[(a - 7'h46) >> 1]};
	endfunction

	// top three numerator bits read back the live reverse flags, phase a highest
	function automatic logic [15:0] exp_rd(input logic [6:0] a);
		if (a == 7'h45) return {active_reverse, model[a][12:0]};
		if (a == 7'h47) return {reactive_reverse, model[a][12:0]};
		return model[a];
	endfunction

	function automatic logic [7:0] ones(input logic [15:0] v);
		ones = 8'h00;
		for (int i = 0; i < 16; i++) ones += {7'h00, v[i]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		logic [15:0] d;
		i_mcr_host.xfer(1'b1, a, v, len(a), len(a), d);
		if (mk(a) != 16'h0000) model[a] = v & mk(a);
	endtask

	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		i_mcr_host.xfer(1'b0, a, 16'h0000, len(a), len(a), v);
	endtask

	task automatic check_ports();
		for (int a = 44; a <= 72; a++) cmp(port_of(7'(a)), model[a]);
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, sized for roughly 60k cycles of traffic
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			mismatches++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [15:0] v;
		logic [7:0] e;
		for (int a = 44; a <= 72; a++) model[a] = (a == 70 || a == 72) ? 16'h003F : 16'h0000;
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (10) @(negedge sys_clk);
		check_ports();
		// pass 0 reads reset values, passes 1 and 2 write complementary patterns
		for (int p = 0; p < 3; p++)
		begin
			active_reverse = 3'b100 >> p;
			reactive_reverse = ~(3'b100 >> p);
			for (int a = 44; a <= 72; a++)
			begin
				v = 16'hB6D9 ^ {2{8'(a)}};
				if (p > 0) wr(7'(a), (p == 1) ? v : ~v);
				rd(7'(a), v);
				cmp(v & mk(7'(a)), exp_rd(7'(a)));
			end
			check_ports();
		end
		rd(7'h45, v);
		e = ones(exp_rd(7'h45));
		rd(7'h7E, v);
		cmp(v, {8'h00, e});
		rd(7'h7E, v);
		cmp(v, {8'h00, ones({8'h00, e})});
		// read-only places ignore writes
		wr(7'h7F, 16'h0000);
		rd(7'h7F, v);
		cmp(v, {8'h00, VERSION});
		wr(7'h7E, 16'h00FF);
		rd(7'h7E, v);
		cmp(v, {8'h00, ones({8'h00, VERSION})});
		// reserved and lower addresses
		foreach (v[i])
		begin
			if (i < 4)
			begin
				wr(i == 0 ? 7'h2B : i == 1 ? 7'h49 : i == 2 ? 7'h60 : 7'h7D, 16'h00FF);
				rd(i == 0 ? 7'h2B : i == 1 ? 7'h49 : i == 2 ? 7'h60 : 7'h7D, v);
				cmp(v, 16'h0000);
				v = 16'h0000;
			end
		end
		// frame cut short after four data bits leaves the divider alone
		i_mcr_host.xfer(1'b1, 7'h42, 16'h00FF, 8, 4, v);
		check_ports();
		cmp({15'h0000, spi_sdo_oe_n}, 16'h0001);
		// reset in mid-run puts every written register back to its reset value
		resetn = 1'b0;
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (10) @(negedge sys_clk);
		for (int a = 44; a <= 72; a++) model[a] = (a == 70 || a == 72) ? 16'h003F : 16'h0000;
		check_ports();
		rd(7'h7E, v);
		cmp(v, 16'h0000);
		print_verdict();
	end
endmodule
